/* File: verilog/mitb_params.svh */
/*
  Constants of the interrupt and periodic tick block: register offsets, field positions, reset values
  and the bit order of the interrupt request and enable registers.
  Assumes inclusion by bare name from the design files and the package.
*/
`ifndef MITB_PARAMS_SVH
`define MITB_PARAMS_SVH

// Register word offsets (byte addresses on APB)
`define MITB_OFF_TICK_CTRL   12'h000
`define MITB_OFF_PSC_SRC     12'h004
`define MITB_OFF_ENABLE      12'h008
`define MITB_OFF_FLAGS       12'h00c
`define MITB_OFF_FLAG_SET    12'h010
`define MITB_OFF_STACK       12'h014

// Periodic tick control fields
`define MITB_TICK_RUN_BIT    7
`define MITB_TICK_PER_MSB    2
`define MITB_TICK_PER_LSB    0
`define MITB_TICK_CTRL_RST   8'h00
`define MITB_PSC_SRC_RST     2'h0
`define MITB_TICK_BASE_LOG2  8

// Prescaler source codes
`define MITB_SRC_SYS         2'h0
`define MITB_SRC_SYS_DIV4    2'h1

// Request flag and enable bit positions
`define MITB_BIT_CONV        0
`define MITB_BIT_TICK        1
`define MITB_BIT_MF0         2
`define MITB_BIT_MF1         3
`define MITB_BIT_TM_A        4
`define MITB_BIT_TM_P        5
`define MITB_BIT_EEPROM      6
`define MITB_BIT_LOWV        7
`define MITB_BIT_GLOBAL      8
`define MITB_NUM_FLAGS       8
`define MITB_NUM_ENABLES     9

// Vector codes, lower code wins
`define MITB_VEC_NONE        3'h0
`define MITB_VEC_MF0         3'h1
`define MITB_VEC_MF1         3'h2
`define MITB_VEC_TICK        3'h3
`define MITB_VEC_CONV        3'h4

`define MITB_STACK_DEPTH     4'h8

`endif

/* File: verilog/mitb_pkg.sv */
/*
  Types shared by the interrupt controller and the core-side end.
  Assumes mitb_params.svh for widths.
*/
`default_nettype none
`include "mitb_params.svh"

package mitb_pkg;
  typedef enum logic [1:0] {
    mitb_idle_st,
    mitb_setup_st,
    mitb_access_st
  } mitb_apb_state_t;

  typedef logic [`MITB_NUM_FLAGS-1:0]   mitb_flags_t;
  typedef logic [`MITB_NUM_ENABLES-1:0] mitb_enables_t;
endpackage

`default_nettype wire

/* File: verilog/mitb_if.sv */
/*
  Link between the interrupt controller and the CPU core sequencer.
  Assumes one clock shared by both ends.
*/
`default_nettype none

interface mitb_if;
  logic       irq_take;
  logic [2:0] irq_vector;
  logic       irq_ack;
  logic       ret_plain;
  logic       ret_irq;
  logic       stack_full;
  logic       wake;
  logic       sleeping;

  modport ctrl
  (
    output irq_take,
    output irq_vector,
    output wake,
    input  irq_ack,
    input  ret_plain,
    input  ret_irq,
    input  stack_full,
    input  sleeping
  );

  modport core
  (
    input  irq_take,
    input  irq_vector,
    input  wake,
    output irq_ack,
    output ret_plain,
    output ret_irq,
    output stack_full,
    output sleeping
  );
endinterface

`default_nettype wire

/* File: verilog/mitb_core_end.sv */
/*
  Core-side end: a small sequencer model of the CPU's interrupt entry and return, driven from APB.
  Software registers: op (write 2 = plain return, 3 = return from interrupt, 4 = enter sleep); a
  pending request is acknowledged by the sequencer itself; status read gives stack level and last vector.
  Assumes the controller end on the mitb_if link and one clock.
*/
`default_nettype none
`include "mitb_params.svh"

module mitb_core_end
  import mitb_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  mitb_if.core             link
);
  typedef struct packed {
    logic [3:0]  level;
    logic [2:0]  last_vec;
    logic        asleep;
    logic        ack;
    logic        rp;
    logic        ri;
    logic [31:0] rdata;
  } mitb_core_state_t;

  mitb_core_state_t s;
  mitb_core_state_t next_s;

  logic wr;

  assign wr      = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign prdata  = s.rdata;

  always_comb
  begin
    next_s     = s;
    next_s.ack = 1'b0;
    next_s.rp  = 1'b0;
    next_s.ri  = 1'b0;
    // Only the program counter is pushed; the service code saves the rest
    if (link.irq_take && !s.ack && s.level != `MITB_STACK_DEPTH)
    begin
      next_s.ack      = 1'b1;
      next_s.level    = s.level + 4'h1;
      next_s.last_vec = link.irq_vector;
    end
    if (link.wake)
      next_s.asleep = 1'b0;
    if (wr && paddr == 12'h000)
    begin
      case (pwdata[2:0])
        3'h2:
        begin
          next_s.rp = 1'b1;
          if (s.level != 4'h0)
            next_s.level = s.level - 4'h1;
        end
        3'h3:
        begin
          next_s.ri = 1'b1;
          if (s.level != 4'h0)
            next_s.level = s.level - 4'h1;
        end
        3'h4:    next_s.asleep = 1'b1;
        default: next_s.asleep = s.asleep;
      endcase
    end
    next_s.rdata = {24'h000000, s.asleep, s.last_vec, s.level};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= '0;
    else if (clk_en)
      s <= next_s;
  end

  assign link.irq_ack    = s.ack;
  assign link.ret_plain  = s.rp;
  assign link.ret_irq    = s.ri;
  assign link.stack_full = (s.level == `MITB_STACK_DEPTH);
  assign link.sleeping   = s.asleep;
endmodule // mitb_core_end

`default_nettype wire

/* File: verilog/mitb_ctrl.sv */
/*
  Interrupt controller with the second periodic tick generator, converter, combined interrupts,
  wake-up and return handling; registers over APB.
  Assumes a CPU sequencer on mitb_if and peripheral event pulses on the same clock.
*/
// What this block does
// - Tick runs only while run bit set
// - Period select gives 2^8 to 2^15 clocks
// - Source: system, system/4, or sub clock
// - Converter done sets flag; gated vector
// - Converter service clears flag and global enable
// - Two combined vectors fed by sources
// - Source flag rise sets combined flag
// - Combined service clears combined flag and global enable only
// - Software clears individual source flags
// - EEPROM done flag, three enables gate
// - Low voltage flag, three enables gate
// - Timer has A and P match sources
// - Timer vector needs three enables, stack
// - Any flag rise wakes from sleep
// - Software presets flag to block wake
// - Flags hold until serviced or cleared
// - Only program counter pushed on entry
// - Return from interrupt sets global enable
// - Avoid calls inside service code
// - No acknowledge while stack full
// - Source select field; overflow sets tick flag
`default_nettype none
`include "mitb_params.svh"

module mitb_ctrl
  import mitb_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sub_clk,
  input  wire logic        conv_done,
  input  wire logic        eeprom_done,
  input  wire logic        low_voltage,
  input  wire logic        tm_match_a,
  input  wire logic        tm_match_p,
  mitb_if.ctrl             link
);
  typedef struct packed {
    logic [7:0]    tick_ctrl;
    logic [1:0]    psc_src;
    mitb_enables_t en;
    mitb_flags_t   flags;
    logic [14:0]   tick_cnt;
    logic [1:0]    div4;
    logic [2:0]    sub_sync;
    logic          sub_level;
    logic          lv_prev;
    logic          pend;
    logic [2:0]    vec;
    logic [31:0]   rdata;
    logic          wake;
  } mitb_ctrl_state_t;

  mitb_ctrl_state_t s;
  mitb_ctrl_state_t next_s;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [14:0] tick_limit(input logic [2:0] code);
    tick_limit = 15'((32'h1 << (`MITB_TICK_BASE_LOG2 + 32'(code))) - 32'h1);
  endfunction

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = psel && penable && (a == off);
  endfunction

  logic        wr;
  logic        psc_tick;
  logic [2:0]  win;
  logic        mf0_req;
  logic        mf1_req;
  logic [7:0]  ev;
  mitb_flags_t raised;

  assign wr      = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign prdata  = s.rdata;

  always_comb
  begin
    // ****************************************
    // Prescaler clock and periodic tick
    // ****************************************
    case (s.psc_src)
      `MITB_SRC_SYS:      psc_tick = 1'b1;
      `MITB_SRC_SYS_DIV4: psc_tick = (s.div4 == 2'h3);
      // Rising sub clock edges only, once the second and third stage agree
      default:            psc_tick = (s.sub_sync[2] == s.sub_sync[1]) && s.sub_sync[2] && !s.sub_level;
    endcase

    ev = '0;
    ev[`MITB_BIT_CONV]   = conv_done;
    ev[`MITB_BIT_TM_A]   = tm_match_a;
    ev[`MITB_BIT_TM_P]   = tm_match_p;
    ev[`MITB_BIT_EEPROM] = eeprom_done;
    ev[`MITB_BIT_LOWV]   = low_voltage && !s.lv_prev;
    ev[`MITB_BIT_TICK]   = s.tick_ctrl[`MITB_TICK_RUN_BIT] && psc_tick &&
                           (s.tick_cnt == tick_limit(s.tick_ctrl[2:0]));

    // Groups: timer sources on the first combined vector, EEPROM and low voltage on the second
    // A combined vector also needs one pending source whose own enable is set
    mf0_req = s.en[`MITB_BIT_MF0] && s.flags[`MITB_BIT_MF0] &&
              |(s.en[`MITB_BIT_TM_P:`MITB_BIT_TM_A] & s.flags[`MITB_BIT_TM_P:`MITB_BIT_TM_A]);
    mf1_req = s.en[`MITB_BIT_MF1] && s.flags[`MITB_BIT_MF1] &&
              |(s.en[`MITB_BIT_LOWV:`MITB_BIT_EEPROM] & s.flags[`MITB_BIT_LOWV:`MITB_BIT_EEPROM]);

    // Fixed priority among enabled pending requests
    if (!s.en[`MITB_BIT_GLOBAL] || link.stack_full)
      win = `MITB_VEC_NONE;
    else if (mf0_req)
      win = `MITB_VEC_MF0;
    else if (mf1_req)
      win = `MITB_VEC_MF1;
    else if (s.en[`MITB_BIT_TICK] && s.flags[`MITB_BIT_TICK])
      win = `MITB_VEC_TICK;
    else if (s.en[`MITB_BIT_CONV] && s.flags[`MITB_BIT_CONV])
      win = `MITB_VEC_CONV;
    else
      win = `MITB_VEC_NONE;

    next_s           = s;
    next_s.lv_prev   = low_voltage;
    next_s.sub_sync  = {s.sub_sync[1:0], sub_clk};
    next_s.div4      = s.div4 + 2'h1;
    next_s.wake      = 1'b0;
    if (s.sub_sync[2] == s.sub_sync[1])
      next_s.sub_level = s.sub_sync[2];

    if (!s.tick_ctrl[`MITB_TICK_RUN_BIT])
      next_s.tick_cnt = '0;
    else if (psc_tick)
      next_s.tick_cnt = ev[`MITB_BIT_TICK] ? 15'h0000 : s.tick_cnt + 15'h0001;

    // ****************************************
    // Register writes, then service clears, then hardware sets
    // ****************************************
    if (wr && hit(paddr, `MITB_OFF_TICK_CTRL))
      next_s.tick_ctrl = {pwdata[7], 4'h0, pwdata[2:0]};
    if (wr && hit(paddr, `MITB_OFF_PSC_SRC))
      next_s.psc_src = pwdata[1:0];
    if (wr && hit(paddr, `MITB_OFF_ENABLE))
      next_s.en = pwdata[`MITB_NUM_ENABLES-1:0];
    if (wr && hit(paddr, `MITB_OFF_FLAGS))
      next_s.flags = s.flags & ~pwdata[`MITB_NUM_FLAGS-1:0];
    if (wr && hit(paddr, `MITB_OFF_FLAG_SET))
      next_s.flags = s.flags | pwdata[`MITB_NUM_FLAGS-1:0];

    next_s.pend = s.pend && !link.irq_ack;
    if (!s.pend && win != `MITB_VEC_NONE)
    begin
      next_s.pend = 1'b1;
      next_s.vec  = win;
    end
    if (link.irq_ack && s.pend)
    begin
      next_s.en[`MITB_BIT_GLOBAL] = 1'b0;
      next_s.pend                 = 1'b0;
      case (s.vec)
        `MITB_VEC_MF0:  next_s.flags[`MITB_BIT_MF0]  = 1'b0;
        `MITB_VEC_MF1:  next_s.flags[`MITB_BIT_MF1]  = 1'b0;
        `MITB_VEC_TICK: next_s.flags[`MITB_BIT_TICK] = 1'b0;
        `MITB_VEC_CONV: next_s.flags[`MITB_BIT_CONV] = 1'b0;
        default:        next_s.pend = 1'b0;
      endcase
    end
    if (link.ret_irq)
      next_s.en[`MITB_BIT_GLOBAL] = 1'b1;

    // Hardware sets win over clears; flags stay until serviced or cleared
    raised = mitb_flags_t'(ev) & ~s.flags;
    next_s.flags = next_s.flags | mitb_flags_t'(ev);
    if (ev[`MITB_BIT_TM_A] || ev[`MITB_BIT_TM_P])
      next_s.flags[`MITB_BIT_MF0] = 1'b1;
    if (ev[`MITB_BIT_EEPROM] || ev[`MITB_BIT_LOWV])
      next_s.flags[`MITB_BIT_MF1] = 1'b1;
    // A flag rise wakes the core whatever the enables say
    if (link.sleeping && (|(next_s.flags & ~s.flags) || |raised))
      next_s.wake = 1'b1;

    case (paddr)
      `MITB_OFF_TICK_CTRL: next_s.rdata = {24'h000000, s.tick_ctrl};
      `MITB_OFF_PSC_SRC:   next_s.rdata = {30'h00000000, s.psc_src};
      `MITB_OFF_ENABLE:    next_s.rdata = {23'h000000, s.en};
      `MITB_OFF_FLAGS:     next_s.rdata = {24'h000000, s.flags};
      `MITB_OFF_STACK:     next_s.rdata = {28'h0000000, link.stack_full, s.vec};
      default:             next_s.rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= '0;
    else if (clk_en)
      s <= next_s;
  end

  // Request held until the core acknowledges it; stack full is checked when it is latched,
  // so the request stays up in the acknowledge cycle even if that push fills the stack
  assign link.irq_take   = s.pend;
  assign link.irq_vector = s.vec;
  assign link.wake       = s.wake;
endmodule // mitb_ctrl

`default_nettype wire

/* File: tb/mitb_asserts.sv */
/*
  Checker for the link between the interrupt controller and the core end.
  Assumes one clock and reset; instantiated beside the mitb_if instance.
*/
`default_nettype none

module mitb_asserts
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       irq_take,
  input wire logic [2:0] irq_vector,
  input wire logic       irq_ack,
  input wire logic       stack_full,
  input wire logic       wake,
  input wire logic       sleeping
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_take_holds; irq_take && !irq_ack |=> irq_take; endproperty
  a_take_holds: assert property (p_take_holds) else $error("request dropped before ack");
  property p_vec_stable; irq_take && !irq_ack |=> $stable(irq_vector); endproperty
  a_vec_stable: assert property (p_vec_stable) else $error("vector moved while pending");
  property p_vec_legal; irq_take |-> irq_vector inside {[3'h1:3'h4]}; endproperty
  a_vec_legal: assert property (p_vec_legal) else $error("illegal vector code");
  property p_ack_bound; $rose(irq_take) |-> ##[1:4] irq_ack; endproperty
  a_ack_bound: assert property (p_ack_bound) else $error("request not acknowledged");
  property p_ack_blocks; irq_ack |=> !irq_take [*2]; endproperty
  a_ack_blocks: assert property (p_ack_blocks) else $error("entry did not block requests");
  property p_full; stack_full && !irq_take |=> !irq_take; endproperty
  a_full: assert property (p_full) else $error("request raised with stack full");
  property p_ack_cause; irq_ack |-> irq_take; endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_wake; wake |-> $past(sleeping); endproperty
  a_wake: assert property (p_wake) else $error("wake while not sleeping");
endmodule // mitb_asserts

`default_nettype wire

/* File: tb/tb_mitb.sv */
/*
  Testbench: drives both ends over their APB ports and the event inputs.
  Assumes the controller and core end joined by one mitb_if.
*/
`default_nettype none

module tb_mitb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, clk_en = 1, penable = 0, pwrite = 0, psel_c = 0, psel_k = 0, sub_clk = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata_c, prdata_k, rdat;
  logic pready_c, pready_k, pslverr_c, pslverr_k, low_voltage = 0;
  logic conv_done = 0, eeprom_done = 0, tm_match_a = 0, tm_match_p = 0;
  int err_count = 0, checks = 0, wake_cnt = 0, n0;

  mitb_if mitb_if_inst ();
  mitb_ctrl mitb_ctrl_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel_c), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_c), .pready(pready_c), .pslverr(pslverr_c),
    .sub_clk(sub_clk), .conv_done(conv_done), .eeprom_done(eeprom_done), .low_voltage(low_voltage),
    .tm_match_a(tm_match_a), .tm_match_p(tm_match_p), .link(mitb_if_inst));
  mitb_core_end mitb_core_end_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel_k),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_k),
    .pready(pready_k), .pslverr(pslverr_k), .link(mitb_if_inst));
  mitb_asserts mitb_asserts_inst (.pclk(pclk), .presetn(presetn), .irq_take(mitb_if_inst.irq_take),
    .irq_vector(mitb_if_inst.irq_vector), .irq_ack(mitb_if_inst.irq_ack), .stack_full(mitb_if_inst.stack_full),
    .wake(mitb_if_inst.wake), .sleeping(mitb_if_inst.sleeping));

  initial forever #50 pclk = ~pclk;
  // Sub clock is not a multiple of pclk, so the synchroniser sees drifting phase
  initial forever #370 sub_clk = ~sub_clk;
  always @(posedge pclk) if (mitb_if_inst.wake === 1'b1) wake_cnt++;

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input bit k, input bit w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_c <= !k;
    psel_k <= k;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while ((k ? pready_k : pready_c) !== 1'b1 && n < 50);
    rdat = k ? prdata_k : prdata_c;
    chk("pslverr", 32'h0, {31'h0, k ? pslverr_k : pslverr_c});
    if (n >= 50)
    begin
      err_count++;
      print_verdict();
    end
    psel_c <= 1'b0;
    psel_k <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd_chk(input bit k, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                        input string nm);
    apb(k, 1'b0, a, '0);
    chk(nm, e, rdat & m);
  endtask

  task automatic wait_level(input logic [3:0] lv);
    int n;
    n = 0;
    do
    begin
      apb(1'b1, 1'b0, 12'h000, '0);
      n++;
    end
    while (rdat[3:0] !== lv && n < 50);
    chk("stack level", {28'h0, lv}, {28'h0, rdat[3:0]});
    if (rdat[3:0] !== lv)
      print_verdict();
  endtask

  // Order of m: {tm_match_p, tm_match_a, eeprom_done, conv_done}
  task automatic ev(input logic [3:0] m);
    {tm_match_p, tm_match_a, eeprom_done, conv_done} <= m;
    @(posedge pclk);
    {tm_match_p, tm_match_a, eeprom_done, conv_done} <= 4'h0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic tick(input logic [1:0] src, input logic [2:0] code, input int lo, input int hi);
    apb(0, 1, 12'h000, 32'h0);
    apb(0, 1, 12'h004, {30'h0, src});
    apb(0, 1, 12'h00c, 32'hff);
    apb(0, 1, 12'h000, {24'h0, 5'h10, code});
    repeat (lo) @(posedge pclk);
    rd_chk(0, 12'h00c, 32'h2, 32'h0, "tick early");
    repeat (hi - lo) @(posedge pclk);
    rd_chk(0, 12'h00c, 32'h2, 32'h2, "tick due");
  endtask

  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(0, 12'h000, '1, 32'h0, "tick ctrl reset");
    rd_chk(0, 12'h004, '1, 32'h0, "source reset");
    apb(0, 1, 12'h0f0, 32'hffffffff);
    rd_chk(0, 12'h0f0, '1, 32'h0, "unmapped");
    tick(2'h0, 3'h0, 200, 300);
    tick(2'h0, 3'h3, 1900, 2200);
    tick(2'h1, 3'h0, 900, 1150);
    tick(2'h2, 3'h0, 1700, 2100);
    tick(2'h3, 3'h0, 1700, 2100);
    apb(0, 1, 12'h000, 32'h0);
    apb(0, 1, 12'h00c, 32'hff);
    repeat (400) @(posedge pclk);
    rd_chk(0, 12'h00c, 32'h2, 32'h0, "tick stopped");
    // Clock enable low must freeze the prescaler and tick counter
    apb(0, 1, 12'h004, 32'h0);
    apb(0, 1, 12'h000, 32'h80);
    clk_en <= 1'b0;
    repeat (300) @(posedge pclk);
    clk_en <= 1'b1;
    rd_chk(0, 12'h00c, 32'h2, 32'h0, "frozen tick");
    repeat (300) @(posedge pclk);
    rd_chk(0, 12'h00c, 32'h2, 32'h2, "tick after freeze");
    apb(0, 1, 12'h000, 32'h0);
    apb(0, 1, 12'h00c, 32'hff);
    apb(0, 1, 12'h008, 32'h1);
    ev(4'h1);
    rd_chk(0, 12'h00c, 32'h1, 32'h1, "conv flag");
    rd_chk(1, 12'h000, 32'hf, 32'h0, "no entry");
    apb(0, 1, 12'h008, 32'h101);
    wait_level(4'h1);
    rd_chk(1, 12'h000, 32'h70, 32'h40, "conv vector");
    rd_chk(0, 12'h00c, 32'h1, 32'h0, "conv flag cleared");
    rd_chk(0, 12'h008, 32'h100, 32'h0, "global cleared");
    apb(1, 1, 12'h000, 32'h3);
    wait_level(4'h0);
    rd_chk(0, 12'h008, 32'h100, 32'h100, "global after return_from_interrupt_op");
    ev(4'h1);
    wait_level(4'h1);
    apb(1, 1, 12'h000, 32'h2);
    wait_level(4'h0);
    rd_chk(0, 12'h008, 32'h100, 32'h0, "global after ret");
    apb(0, 1, 12'h008, 32'h15c);
    ev(4'h6);
    wait_level(4'h1);
    rd_chk(1, 12'h000, 32'h70, 32'h10, "first vector");
    rd_chk(0, 12'h00c, 32'hff, 32'h58, "flags after mf0");
    apb(1, 1, 12'h000, 32'h3);
    repeat (8) @(posedge pclk);
    rd_chk(1, 12'h000, 32'h7f, 32'h21, "second vector");
    rd_chk(0, 12'h00c, 32'hff, 32'h50, "flags after mf1");
    apb(0, 1, 12'h00c, 32'h50);
    rd_chk(0, 12'h00c, 32'hff, 32'h0, "sources cleared");
    apb(0, 1, 12'h008, 32'h0);
    apb(1, 1, 12'h000, 32'h2);
    wait_level(4'h0);
    low_voltage <= 1'b1;
    ev(4'h8);
    rd_chk(0, 12'h00c, 32'hff, 32'hac, "timer p and low voltage");
    low_voltage <= 1'b0;
    apb(0, 1, 12'h008, 32'h10c);
    repeat (8) @(posedge pclk);
    rd_chk(1, 12'h000, 32'hf, 32'h0, "combined needs source enable");
    apb(0, 1, 12'h008, 32'h0);
    apb(0, 1, 12'h00c, 32'hff);
    for (int i = 0; i < 8; i++)
    begin
      apb(0, 1, 12'h010, 32'h1);
      apb(0, 1, 12'h008, 32'h101);
      wait_level(4'(i + 1));
    end
    apb(0, 1, 12'h010, 32'h1);
    apb(0, 1, 12'h008, 32'h101);
    repeat (10) @(posedge pclk);
    rd_chk(1, 12'h000, 32'hf, 32'h8, "full level");
    rd_chk(0, 12'h00c, 32'h1, 32'h1, "held flag");
    rd_chk(0, 12'h014, 32'h8, 32'h8, "full status");
    apb(1, 1, 12'h000, 32'h2);
    repeat (10) @(posedge pclk);
    rd_chk(1, 12'h000, 32'hf, 32'h8, "taken after pop");
    rd_chk(0, 12'h00c, 32'h1, 32'h0, "flag after pop");
    apb(0, 1, 12'h008, 32'h0);
    for (int i = 0; i < 8; i++)
      apb(1, 1, 12'h000, 32'h2);
    wait_level(4'h0);
    apb(1, 1, 12'h000, 32'h4);
    rd_chk(1, 12'h000, 32'h80, 32'h80, "asleep");
    n0 = wake_cnt;
    ev(4'h2);
    chk("wake", 32'(n0 + 1), 32'(wake_cnt));
    apb(1, 1, 12'h000, 32'h4);
    ev(4'h2);
    chk("no wake", 32'(n0 + 1), 32'(wake_cnt));
    print_verdict();
  end
endmodule // tb_mitb

`default_nettype wire
